/* rtl/alert_pkg.sv */
/*
 * Constants for the alert and command-pacing block of the optical
 * proximity / ambient-light sensor: register indices, field positions,
 * reset values.
 * Assumes a host-side serial front end that turns bus frames into
 * single-cycle register read and write strobes on the core clock.
 */
package alert_pkg;

    // ********************************************************************
    // Register indices on the internal register port
    // ********************************************************************
    localparam logic [7:0] PIN_CONFIG_IDX   = 8'h00;
    localparam logic [7:0] SOURCE_MASK_IDX  = 8'h01;
    localparam logic [7:0] SELECT_A_IDX     = 8'h02;
    localparam logic [7:0] SELECT_B_IDX     = 8'h03;
    localparam logic [7:0] FLAGS_IDX        = 8'h04;
    localparam logic [7:0] DRIVE_AB_IDX     = 8'h05;
    localparam logic [7:0] DRIVE_C_IDX      = 8'h06;
    localparam logic [7:0] PICK_AB_IDX      = 8'h07;
    localparam logic [7:0] PICK_C_IDX       = 8'h08;
    localparam logic [7:0] RATE_IDX         = 8'h09;
    localparam logic [7:0] REPLY_IDX        = 8'h0a;
    localparam logic [7:0] CHIP_STATE_IDX   = 8'h0b;

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int PIN_OE_BIT       = 0;  // Pin output enable
    localparam int PIN_POLICY_BIT   = 1;  // Clear policy
    localparam int AMBIENT_LSB      = 0;  // Two-bit ambient field
    localparam int PROX_ONE_BIT     = 2;
    localparam int PROX_TWO_BIT     = 3;
    localparam int PROX_THREE_BIT   = 4;
    localparam int NUM_SOURCES      = 5;
    localparam int PROX_ONE_SEL_LSB = 4;  // In select_a
    localparam int PROX_TWO_SEL_LSB = 6;  // In select_a
    localparam int PROX_THREE_SEL_LSB = 0; // In select_b
    localparam int AMBIENT_SEL_LSB  = 0;  // Three bits in select_a
    localparam int PICK_ONE_LSB     = 0;  // In pick_ab, three bits
    localparam int PICK_TWO_LSB     = 4;  // In pick_ab, three bits
    localparam int PICK_THREE_LSB   = 0;  // In pick_c, three bits
    localparam int CURRENT_A_LSB    = 0;  // In drive_ab, four bits
    localparam int CURRENT_B_LSB    = 4;  // In drive_ab, four bits
    localparam int CURRENT_C_LSB    = 0;  // In drive_c, four bits

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [7:0] CONFIG_RESET  = 8'h00;
    localparam logic [4:0] FLAGS_RESET   = 5'h00;
    localparam logic [3:0] COUNT_RESET   = 4'h0;
    localparam logic [7:0] READ_RESET    = 8'h00;

endpackage

/* rtl/sensor_irq_and_command_pacing.sv */
/*
 * Alert generation and reply counter for the sensor core: the pin
 * configuration, source mask, trigger selects, emitter picks and drive
 * codes, the sticky alert flags, and the reply counter that the host
 * polls to pace its commands.
 * Assumes a serial front end on the same clock that issues one-cycle
 * register strobes, and a measurement sequencer on the same clock that
 * pulses source events, command completion and no-operation.
 */
// Functional notes
// - Forced result shows on pin or flags; here on neither unless its source mask bit is set
// - Pin driven only when enable bit set
// - Pin asserts when mask AND flags nonzero
// - Policy bit selects how pin deasserts
// - Writing one clears only that flag
// - Prox bits 2..4, ambient bits 1:0
// - Trigger select fields at documented positions
// - Emitter pick fields at documented positions
// - Drive current codes at documented positions
// - Reply holds zero nibble plus circular counter
`timescale 1ns/1ps

module sensor_irq_and_command_pacing (
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic                        ce,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    output logic      [7:0]                  reg_rdata,
    input  wire logic [alert_pkg::NUM_SOURCES-1:0] source_event,
    input  wire logic                        cmd_done,
    input  wire logic                        cmd_nop,
    input  wire logic [7:0]                  chip_state,
    output logic      [7:0]                  autonomous_rate,
    output logic      [1:0]                  prox_one_trigger_sel,
    output logic      [1:0]                  prox_two_trigger_sel,
    output logic      [1:0]                  prox_three_trigger_sel,
    output logic      [2:0]                  ambient_trigger_sel,
    output logic      [2:0]                  emitter_pick_one,
    output logic      [2:0]                  emitter_pick_two,
    output logic      [2:0]                  emitter_pick_c,
    output logic      [3:0]                  emitter_a_current,
    output logic      [3:0]                  emitter_b_current,
    output logic      [3:0]                  emitter_c_current,
    output logic                             alert_pin_out,
    output logic                             alert_pin_oe
);

    // ********************************************************************
    // State
    // ********************************************************************
    logic [7:0] alert_pin_config_r, alert_pin_config_nxt;
    logic [7:0] alert_source_mask_r, alert_source_mask_nxt;
    logic [7:0] alert_select_a_r, alert_select_a_nxt;
    logic [7:0] alert_select_b_r, alert_select_b_nxt;
    logic [7:0] emitter_drive_ab_r, emitter_drive_ab_nxt;
    logic [7:0] emitter_drive_c_r, emitter_drive_c_nxt;
    logic [7:0] emitter_pick_ab_r, emitter_pick_ab_nxt;
    logic [7:0] emitter_pick_c_r, emitter_pick_c_nxt;
    logic [7:0] autonomous_rate_r, autonomous_rate_nxt;
    logic [alert_pkg::NUM_SOURCES-1:0] alert_flags_r, alert_flags_nxt;
    logic [3:0] reply_count_r, reply_count_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       alert_active_r, alert_active_nxt;

    logic       wr_hit_flags;
    logic       rd_hit_flags;
    logic [alert_pkg::NUM_SOURCES-1:0] flag_clear;
    logic [alert_pkg::NUM_SOURCES-1:0] flag_set;

    // Read or write strobe aimed at one register index
    function automatic logic hit(input logic       stb,
                                 input logic [7:0] addr,
                                 input logic [7:0] idx);
        hit = stb && (addr == idx);
    endfunction

    // Register or keep, used for every plain read/write register
    function automatic logic [7:0] rw_next(input logic       stb,
                                           input logic [7:0] addr,
                                           input logic [7:0] idx,
                                           input logic [7:0] wdata,
                                           input logic [7:0] cur);
        rw_next = hit(stb, addr, idx) ? wdata : cur;
    endfunction

    // ********************************************************************
    // Configuration registers
    // ********************************************************************
    // Plain storage; the sequencer reads the fields directly
    always_comb begin
        alert_pin_config_nxt = rw_next(reg_wr, reg_addr,
            alert_pkg::PIN_CONFIG_IDX, reg_wdata, alert_pin_config_r);
        alert_source_mask_nxt = rw_next(reg_wr, reg_addr,
            alert_pkg::SOURCE_MASK_IDX, reg_wdata, alert_source_mask_r);
        alert_select_a_nxt = rw_next(reg_wr, reg_addr,
            alert_pkg::SELECT_A_IDX, reg_wdata, alert_select_a_r);
        alert_select_b_nxt = rw_next(reg_wr, reg_addr,
            alert_pkg::SELECT_B_IDX, reg_wdata, alert_select_b_r);
        emitter_drive_ab_nxt = rw_next(reg_wr, reg_addr,
            alert_pkg::DRIVE_AB_IDX, reg_wdata, emitter_drive_ab_r);
        emitter_drive_c_nxt = rw_next(reg_wr, reg_addr,
            alert_pkg::DRIVE_C_IDX, reg_wdata, emitter_drive_c_r);
        emitter_pick_ab_nxt = rw_next(reg_wr, reg_addr,
            alert_pkg::PICK_AB_IDX, reg_wdata, emitter_pick_ab_r);
        emitter_pick_c_nxt = rw_next(reg_wr, reg_addr,
            alert_pkg::PICK_C_IDX, reg_wdata, emitter_pick_c_r);
        // Zero here stops autonomous measuring in the sequencer
        autonomous_rate_nxt = rw_next(reg_wr, reg_addr,
            alert_pkg::RATE_IDX, reg_wdata, autonomous_rate_r);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            alert_pin_config_r  <= alert_pkg::CONFIG_RESET;
            alert_source_mask_r <= alert_pkg::CONFIG_RESET;
            alert_select_a_r    <= alert_pkg::CONFIG_RESET;
            alert_select_b_r    <= alert_pkg::CONFIG_RESET;
            emitter_drive_ab_r  <= alert_pkg::CONFIG_RESET;
            emitter_drive_c_r   <= alert_pkg::CONFIG_RESET;
            emitter_pick_ab_r   <= alert_pkg::CONFIG_RESET;
            emitter_pick_c_r    <= alert_pkg::CONFIG_RESET;
            autonomous_rate_r   <= alert_pkg::CONFIG_RESET;
        end else if (ce) begin
            alert_pin_config_r  <= alert_pin_config_nxt;
            alert_source_mask_r <= alert_source_mask_nxt;
            alert_select_a_r    <= alert_select_a_nxt;
            alert_select_b_r    <= alert_select_b_nxt;
            emitter_drive_ab_r  <= emitter_drive_ab_nxt;
            emitter_drive_c_r   <= emitter_drive_c_nxt;
            emitter_pick_ab_r   <= emitter_pick_ab_nxt;
            emitter_pick_c_r    <= emitter_pick_c_nxt;
            autonomous_rate_r   <= autonomous_rate_nxt;
        end
    end

    // Field taps toward the sequencer and emitter drivers
    assign autonomous_rate        = autonomous_rate_r;
    assign prox_one_trigger_sel   =
        alert_select_a_r[alert_pkg::PROX_ONE_SEL_LSB +: 2];
    assign prox_two_trigger_sel   =
        alert_select_a_r[alert_pkg::PROX_TWO_SEL_LSB +: 2];
    assign prox_three_trigger_sel =
        alert_select_b_r[alert_pkg::PROX_THREE_SEL_LSB +: 2];
    assign ambient_trigger_sel    =
        alert_select_a_r[alert_pkg::AMBIENT_SEL_LSB +: 3];
    assign emitter_pick_one  =
        emitter_pick_ab_r[alert_pkg::PICK_ONE_LSB +: 3];
    assign emitter_pick_two  =
        emitter_pick_ab_r[alert_pkg::PICK_TWO_LSB +: 3];
    assign emitter_pick_c    =
        emitter_pick_c_r[alert_pkg::PICK_THREE_LSB +: 3];
    assign emitter_a_current =
        emitter_drive_ab_r[alert_pkg::CURRENT_A_LSB +: 4];
    assign emitter_b_current =
        emitter_drive_ab_r[alert_pkg::CURRENT_B_LSB +: 4];
    assign emitter_c_current =
        emitter_drive_c_r[alert_pkg::CURRENT_C_LSB +: 4];

    // ********************************************************************
    // Alert flags, reply counter, pin
    // ********************************************************************
    // Event bits map to sources: ambient 1:0, prox one..three 2..4
    // Set beats clear so an event in the clearing cycle is kept.
    // Policy one clears on a flag read instead of a write
    always_comb begin
        wr_hit_flags = hit(reg_wr, reg_addr, alert_pkg::FLAGS_IDX);
        rd_hit_flags = hit(reg_rd, reg_addr, alert_pkg::FLAGS_IDX);
        flag_set = source_event
                 & alert_source_mask_r[alert_pkg::NUM_SOURCES-1:0];
        flag_clear = '0;
        if (!alert_pin_config_r[alert_pkg::PIN_POLICY_BIT] && wr_hit_flags)
            flag_clear = reg_wdata[alert_pkg::NUM_SOURCES-1:0];
        else if (alert_pin_config_r[alert_pkg::PIN_POLICY_BIT]
                 && rd_hit_flags)
            flag_clear = '1;
        alert_flags_nxt = (alert_flags_r & ~flag_clear) | flag_set;
        // Pin follows the registered AND, so it drops one cycle late
        alert_active_nxt = |(alert_source_mask_r[alert_pkg::NUM_SOURCES-1:0]
                             & alert_flags_r);
        // No-op clears, completion steps modulo sixteen
        if (cmd_nop)
            reply_count_nxt = alert_pkg::COUNT_RESET;
        else if (cmd_done)
            reply_count_nxt = reply_count_r + 4'h1;
        else
            reply_count_nxt = reply_count_r;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            alert_flags_r  <= alert_pkg::FLAGS_RESET;
            reply_count_r  <= alert_pkg::COUNT_RESET;
            alert_active_r <= 1'b0;
        end else if (ce) begin
            alert_flags_r  <= alert_flags_nxt;
            reply_count_r  <= reply_count_nxt;
            alert_active_r <= alert_active_nxt;
        end
    end

    // Open-drain, active low: only ever pulls down, and only when enabled.
    // A forced measurement finishing shows in the flags only when its source mask bit is set, and here only when the pin is also enabled
    assign alert_pin_out = 1'b0;
    assign alert_pin_oe  = alert_active_r
                         & alert_pin_config_r[alert_pkg::PIN_OE_BIT];

    // ********************************************************************
    // Read port
    // ********************************************************************
    // Data comes from a flop one cycle after the read strobe; unmapped
    // indices read zero so a polling host never sees stale bytes
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            case (reg_addr)
                alert_pkg::PIN_CONFIG_IDX:  rdata_nxt = alert_pin_config_r;
                alert_pkg::SOURCE_MASK_IDX: rdata_nxt = alert_source_mask_r;
                alert_pkg::SELECT_A_IDX:    rdata_nxt = alert_select_a_r;
                alert_pkg::SELECT_B_IDX:    rdata_nxt = alert_select_b_r;
                alert_pkg::FLAGS_IDX:
                    rdata_nxt = {3'h0, alert_flags_r};
                alert_pkg::DRIVE_AB_IDX:    rdata_nxt = emitter_drive_ab_r;
                alert_pkg::DRIVE_C_IDX:     rdata_nxt = emitter_drive_c_r;
                alert_pkg::PICK_AB_IDX:     rdata_nxt = emitter_pick_ab_r;
                alert_pkg::PICK_C_IDX:      rdata_nxt = emitter_pick_c_r;
                alert_pkg::RATE_IDX:        rdata_nxt = autonomous_rate_r;
                // Upper nibble zero in the error-free state
                alert_pkg::REPLY_IDX:
                    rdata_nxt = {4'h0, reply_count_r};
                // Host polls this for idle before a command
                alert_pkg::CHIP_STATE_IDX:  rdata_nxt = chip_state;
                default:                    rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst)
            rdata_r <= alert_pkg::READ_RESET;
        else if (ce)
            rdata_r <= rdata_nxt;
    end

    assign reg_rdata = rdata_r;

    // ********************************************************************
    // Checks
    // ********************************************************************
    pin_enable_gate_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !alert_pin_config_r[alert_pkg::PIN_OE_BIT] |-> !alert_pin_oe)
        else $error("alert pin driven while output disabled");

    pin_and_follow_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && (|(alert_source_mask_r[4:0] & alert_flags_r))
        && alert_pin_config_r[0]
        && !(reg_wr && reg_addr == alert_pkg::PIN_CONFIG_IDX)
        |=> alert_pin_oe)
        else $error("alert pin not asserted for masked flag");

    pin_release_late_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && !(|(alert_source_mask_r[4:0] & alert_flags_r))
        |=> !alert_active_r)
        else $error("alert pin did not release after clear");

    flag_w1c_only_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && reg_wr && reg_addr == alert_pkg::FLAGS_IDX
        && !alert_pin_config_r[1] && source_event == 5'h00
        |=> alert_flags_r == ($past(alert_flags_r) & ~$past(reg_wdata[4:0])))
        else $error("flag write cleared wrong bits");

    flag_set_wins_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && source_event[alert_pkg::PROX_ONE_BIT]
        && alert_source_mask_r[alert_pkg::PROX_ONE_BIT]
        |=> alert_flags_r[alert_pkg::PROX_ONE_BIT])
        else $error("enabled proximity event lost");

    policy_read_clear_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && reg_rd && reg_addr == alert_pkg::FLAGS_IDX
        && alert_pin_config_r[1] && !reg_wr && source_event == 5'h00
        |=> alert_flags_r == 5'h00 ##1 !alert_active_r)
        else $error("flag read did not clear under policy one");

    reply_count_step_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && cmd_done && !cmd_nop
        |=> reply_count_r == $past(reply_count_r) + 4'h1)
        else $error("reply counter did not advance");

    reply_nop_clear_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && cmd_nop |=> reply_count_r == alert_pkg::COUNT_RESET)
        else $error("reply not zero after no-operation");

    reply_read_form_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && reg_rd && reg_addr == alert_pkg::REPLY_IDX
        |=> reg_rdata == {4'h0, $past(reply_count_r)})
        else $error("reply read lost its zero upper nibble");

    forced_done_show_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && (|flag_set) && !reg_wr && !reg_rd |=> alert_flags_r != 5'h00)
        else $error("completion event not visible in flags");

endmodule

/* bench/host_model.sv */
/*
 * Host model for the sensor alert block: one register access at a time
 * on the internal strobe port, plus the pacing duties of the host.
 * Assumes the core samples strobes on the rising edge of clk.
 */
`timescale 1ns/1ps

module host_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    // ********************************************************************
    // Bus cycles
    // ********************************************************************
    // Quiet port at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // Strobe held over one rising edge; data inverted once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    // Read data is registered, so it is settled one falling edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask

    // Service: read the flags, write the same copy back
    task automatic clear_flags();
        logic [7:0] v;
        rd(alert_pkg::FLAGS_IDX, v);
        wr(alert_pkg::FLAGS_IDX, v);
    endtask

    // Pacing gap; the host issues nothing while it runs
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
endmodule

/* bench/sensor_irq_and_command_pacing_test.sv */
/*
 * Self-checking bench for the alert and reply-counter block.
 * Assumes the host model drives the register port; the bench drives the
 * sequencer pulses at falling edges and holds ce high except for one frozen write in the fields test.
 */
`timescale 1ns/1ps

module sensor_irq_and_command_pacing_test;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       ce = 1'b1;
    logic       reg_wr, reg_rd, cmd_done = 1'b0, cmd_nop = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, autonomous_rate;
    logic [7:0] chip_state = 8'h01;
    logic [4:0] source_event = 5'h00;
    logic [1:0] prox_one_trigger_sel, prox_two_trigger_sel;
    logic [1:0] prox_three_trigger_sel;
    logic [2:0] ambient_trigger_sel, emitter_pick_one, emitter_pick_two;
    logic [2:0] emitter_pick_c;
    logic [3:0] emitter_a_current, emitter_b_current, emitter_c_current;
    logic       alert_pin_out, alert_pin_oe;
    int         err_total = 0;
    int         total_checks = 0;

    // ********************************************************************
    // Clock, design and host
    // ********************************************************************
    always #2.5 clk = ~clk;

    sensor_irq_and_command_pacing dut (.clk, .nrst, .ce, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .source_event, .cmd_done,
        .cmd_nop, .chip_state, .autonomous_rate, .prox_one_trigger_sel,
        .prox_two_trigger_sel, .prox_three_trigger_sel, .ambient_trigger_sel,
        .emitter_pick_one, .emitter_pick_two, .emitter_pick_c,
        .emitter_a_current, .emitter_b_current, .emitter_c_current,
        .alert_pin_out, .alert_pin_oe);

    host_model host (.clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata);

    // ********************************************************************
    // Shared helpers
    // ********************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host.rd(a, v);
        check(v, exp);
    endtask

    // One-cycle sequencer event, lowered after one rising edge
    task automatic pulse(input logic [4:0] ev);
        @(negedge clk);
        source_event = ev;
        @(negedge clk);
        source_event = 5'h00;
    endtask

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ********************************************************************
    // Scenarios
    // ********************************************************************
    task automatic t_reset();
        check({7'h00, alert_pin_oe}, 8'h00);
        rd_chk(alert_pkg::PIN_CONFIG_IDX, alert_pkg::CONFIG_RESET);
        rd_chk(alert_pkg::FLAGS_IDX, 8'h00);
        rd_chk(alert_pkg::REPLY_IDX, 8'h00);
        $display("test reset done");
    endtask

    // Distinct values per field so a swapped slice shows up
    task automatic t_fields();
        host.wr(alert_pkg::SELECT_A_IDX, 8'hb5);
        host.wr(alert_pkg::SELECT_B_IDX, 8'h02);
        host.wr(alert_pkg::PICK_AB_IDX, 8'h53);
        host.wr(alert_pkg::PICK_C_IDX, 8'h06);
        host.wr(alert_pkg::DRIVE_AB_IDX, 8'ha7);
        host.wr(alert_pkg::DRIVE_C_IDX, 8'h09);
        check({1'b0, prox_two_trigger_sel, prox_one_trigger_sel,
               ambient_trigger_sel}, 8'h5d);
        check({6'h00, prox_three_trigger_sel}, 8'h02);
        check({2'h0, emitter_pick_two, emitter_pick_one}, 8'h2b);
        check({5'h00, emitter_pick_c}, 8'h06);
        check({emitter_b_current, emitter_a_current}, 8'ha7);
        check({4'h0, emitter_c_current}, 8'h09);
        rd_chk(alert_pkg::SELECT_A_IDX, 8'hb5);
        host.wr(alert_pkg::RATE_IDX, 8'h3c);
        check(autonomous_rate, 8'h3c);
        host.wr(alert_pkg::RATE_IDX, 8'h00);
        host.idle(2);
        check(autonomous_rate, 8'h00);
        // Frozen core must ignore a write strobe
        ce = 1'b0;
        host.wr(alert_pkg::RATE_IDX, 8'h77);
        ce = 1'b1;
        check(autonomous_rate, 8'h00);
        $display("test fields done");
    endtask

    task automatic t_alert();
        host.wr(alert_pkg::SOURCE_MASK_IDX, 8'h1c);
        host.wr(alert_pkg::PIN_CONFIG_IDX, 8'h00);
        pulse(5'h05);
        rd_chk(alert_pkg::FLAGS_IDX, 8'h04);
        check({7'h00, alert_pin_oe}, 8'h00);
        host.wr(alert_pkg::PIN_CONFIG_IDX, 8'h01);
        check({7'h00, alert_pin_oe}, 8'h01);
        check({7'h00, alert_pin_out}, 8'h00);
        host.wr(alert_pkg::FLAGS_IDX, 8'h08);
        rd_chk(alert_pkg::FLAGS_IDX, 8'h04);
        host.wr(alert_pkg::FLAGS_IDX, 8'h04);
        check({7'h00, alert_pin_oe}, 8'h01);
        @(negedge clk);
        check({7'h00, alert_pin_oe}, 8'h00);
        host.wr(alert_pkg::SOURCE_MASK_IDX, 8'h1f);
        pulse(5'h1b);
        rd_chk(alert_pkg::FLAGS_IDX, 8'h1b);
        host.clear_flags();
        rd_chk(alert_pkg::FLAGS_IDX, 8'h00);
        $display("test alert done");
    endtask

    // Policy one: flag writes ignored, a read clears
    task automatic t_policy();
        host.wr(alert_pkg::PIN_CONFIG_IDX, 8'h03);
        pulse(5'h10);
        host.wr(alert_pkg::FLAGS_IDX, 8'h10);
        rd_chk(alert_pkg::FLAGS_IDX, 8'h10);
        rd_chk(alert_pkg::FLAGS_IDX, 8'h00);
        $display("test policy done");
    endtask

    task automatic t_reply();
        rd_chk(alert_pkg::CHIP_STATE_IDX, 8'h01);
        repeat (17) begin
            @(negedge clk);
            cmd_done = 1'b1;
            @(negedge clk);
            cmd_done = 1'b0;
        end
        rd_chk(alert_pkg::REPLY_IDX, 8'h01);
        @(negedge clk);
        cmd_done = 1'b1;
        cmd_nop = 1'b1;
        @(negedge clk);
        cmd_done = 1'b0;
        cmd_nop = 1'b0;
        host.wr(alert_pkg::REPLY_IDX, 8'h5f);
        rd_chk(alert_pkg::REPLY_IDX, 8'h00);
        rd_chk(8'h20, 8'h00);
        $display("test reply done");
    endtask

    // ********************************************************************
    // Main sequence and watchdog
    // ********************************************************************
    initial begin
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        t_reset();
        t_fields();
        t_alert();
        t_policy();
        t_reply();
        wrap_up();
    end

    // Tests need about 125 cycles; this allows about forty times more
    initial begin
        #25000;
        err_total = err_total + 1;
        wrap_up();
    end
endmodule
